// ### rtl/ucp_ctrl_pipe.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - Buffer flag shows rx readable when direction select 0, tx writable when 1.
// - Writing 1 to toggle clear/set forces DATA0/DATA1; both read as zero.
// - Toggle monitor flips per normal transaction, not on DATA RESPONSE_SELECT mismatch.
// - A correct Setup packet sets the expected toggle to DATA1.
// - Status stage transactions never flip the toggle monitor.
// - Busy flag rises at transaction start, falls when it completes.
// - Status-complete with BUF response finishes the control transfer.
// - SET_ADDRESS runs autonomously, ignoring status-complete and response.
// - A new Setup packet clears status-complete.
// - Status-complete writes are ignored while setup-received flag is set.
// - Setup forces NAK, raises setup flag, blocks response writes until cleared.
// - Oversize data in BUF switches response to STALL, sequence error to STALL2.
// - USB bus reset forces response to NAK.
// - Select 1 to 9 maps the configuration window onto that pipe.
// - Select 0 reads zeros and discards window writes.
// - Type field: 00 off, 01 bulk, 10 interrupt, 11 isochronous.
// - Ready timing bit: 0 on send/receive, 1 after data read out.
// - Separate bits choose double buffer and continuous mode.
// - Receiving pipe with stop-at-end set goes to NAK at transfer end.
// - Direction bit 0 receive, 1 transmit; 4-bit endpoint number field.
module ucp_ctrl_pipe (
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    input  wire ucp_pkg::ucp_reg_req_t  reg_req_i,
    output logic [15:0]                 reg_rdata_o,
    input  wire ucp_pkg::ucp_link_evt_t link_evt_i,
    input  wire ucp_pkg::ucp_buf_state_t buf_state_i,
    input  wire logic [8:0]             pipe_xfer_end_i,
    output ucp_pkg::ucp_resp_t          ctl_response_o,
    output logic                        ctl_toggle_o,
    output logic                        ctl_status_go_o,
    output logic                        ctl_auto_addr_o,
    output logic [8:0]                  pipe_stop_o,
    output ucp_pkg::ucp_pipe_cfg_t [8:0] pipe_cfg_o
);
    import ucp_pkg::*;

    // True when the window selects a real pipe
    function automatic logic win_valid(input logic [3:0] sel);
        win_valid = (sel != WIN_NONE) && (sel <= WIN_LAST);
    endfunction

    // Array index for a valid selection
    function automatic logic [3:0] win_index(input logic [3:0] sel);
        win_index = sel - 4'h1;
    endfunction

    // State registers
    ucp_resp_t      resp_q;
    logic           toggle_q;
    logic           busy_q;
    logic           stat_cpl_q;
    logic           setup_flag_q;
    logic           auto_addr_q;
    logic           port_dir_q;
    logic           buf_flag_q;
    logic [3:0]     win_sel_q;
    ucp_pipe_cfg_t  cfg_q [NUM_PIPES];
    logic [15:0]    rdata_q;
    logic [8:0]     stop_q;
    logic           status_go_q;

    // Decoded write strobes
    logic wr_ctl;
    logic wr_sel;
    logic wr_cfg;
    logic wr_aux;
    logic status_end;

    // Address decode of the write strobes
    always_comb begin
        wr_ctl = 1'b0;
        wr_sel = 1'b0;
        wr_cfg = 1'b0;
        wr_aux = 1'b0;
        if (reg_req_i.wr && reg_req_i.addr == CTL_PIPE_CONTROL_OFS) begin
            wr_ctl = 1'b1;
        end else if (reg_req_i.wr && reg_req_i.addr == PIPE_WINDOW_SELECT_OFS) begin
            wr_sel = 1'b1;
        end else if (reg_req_i.wr && reg_req_i.addr == PIPE_CONFIGURATION_OFS) begin
            wr_cfg = 1'b1;
        end else if (reg_req_i.wr && reg_req_i.addr == CTL_PIPE_AUX_OFS) begin
            wr_aux = 1'b1;
        end
    end

    // Normal end of a status stage transaction
    assign status_end = link_evt_i.xact_done && link_evt_i.status_stage;

    // Buffer access flag follows the port direction
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            buf_flag_q <= 1'b0;
        end else begin
            buf_flag_q <= port_dir_q ? buf_state_i.tx_writable
                                     : buf_state_i.rx_readable;
        end
    end

    // Port direction select, software owned
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_dir_q <= 1'b0;
        end else if (wr_aux) begin
            port_dir_q <= reg_req_i.wdata[PORT_DIR_BIT];
        end
    end

    // Expected data toggle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            toggle_q <= TOG_MON_RST;
        end else if (link_evt_i.setup_rcvd) begin
            toggle_q <= 1'b1;
        end else if (wr_ctl && reg_req_i.wdata[TOG_CLR_BIT]) begin
            toggle_q <= 1'b0;
        end else if (wr_ctl && reg_req_i.wdata[TOG_SET_BIT]) begin
            toggle_q <= 1'b1;
        end else if (link_evt_i.xact_done && !link_evt_i.pid_mismatch
                     && !link_evt_i.status_stage) begin
            toggle_q <= ~toggle_q;
        end
    end

    // Pipe busy tracking; a fresh start wins over a completion
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_q <= 1'b0;
        end else if (link_evt_i.xact_start) begin
            busy_q <= 1'b1;
        end else if (link_evt_i.xact_done) begin
            busy_q <= 1'b0;
        end
    end

    // Setup received flag; hardware set wins over software clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            setup_flag_q <= 1'b0;
        end else if (link_evt_i.setup_rcvd) begin
            setup_flag_q <= 1'b1;
        end else if (wr_aux && !reg_req_i.wdata[SETUP_FLAG_BIT]) begin
            setup_flag_q <= 1'b0;
        end
    end

    // Status-complete request
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stat_cpl_q <= 1'b0;
        end else if (link_evt_i.setup_rcvd || link_evt_i.bus_reset) begin
            stat_cpl_q <= 1'b0;
        end else if (wr_ctl && reg_req_i.wdata[STAT_CPL_BIT] && !setup_flag_q) begin
            stat_cpl_q <= 1'b1;
        end else if (status_end) begin
            stat_cpl_q <= 1'b0;
        end
    end

    // Autonomous SET_ADDRESS handling
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            auto_addr_q <= 1'b0;
        end else if (link_evt_i.bus_reset) begin
            auto_addr_q <= 1'b0;
        end else if (link_evt_i.set_address) begin
            auto_addr_q <= 1'b1;
        end else if (status_end) begin
            auto_addr_q <= 1'b0;
        end
    end

    // Handshake response field
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            resp_q <= RESP_NAK;
        end else if (link_evt_i.bus_reset) begin
            resp_q <= RESP_NAK;
        end else if (link_evt_i.setup_rcvd) begin
            resp_q <= RESP_NAK;
        end else if (link_evt_i.oversize && resp_q == RESP_BUF) begin
            resp_q <= RESP_STALL;
        end else if (link_evt_i.seq_error) begin
            resp_q <= RESP_STALL2;
        end else if (wr_ctl && !setup_flag_q) begin
            resp_q <= ucp_resp_t'(reg_req_i.wdata[RESP_LSB +: 2]);
        end
    end

    // Status stage permission towards the protocol engine
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_go_q <= 1'b0;
        end else begin
            status_go_q <= auto_addr_q
                || (stat_cpl_q && resp_q == RESP_BUF);
        end
    end

    // Pipe window select
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            win_sel_q <= WIN_SEL_RST;
        end else if (wr_sel) begin
            win_sel_q <= reg_req_i.wdata[WIN_SEL_W-1:0];
        end
    end

    // Per-pipe configuration storage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_PIPES; i++) begin
                cfg_q[i] <= PIPE_CFG_RST;
            end
        end else if (wr_cfg && win_valid(win_sel_q)) begin
            cfg_q[win_index(win_sel_q)] <= reg_req_i.wdata & PIPE_CFG_MASK;
        end
    end

    // Stop-at-end pulses for receiving pipes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stop_q <= '0;
        end else begin
            for (int i = 0; i < NUM_PIPES; i++) begin
                stop_q[i] <= pipe_xfer_end_i[i] && cfg_q[i].stop_at_end_enable
                             && !cfg_q[i].direction;
            end
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= '0;
        end else if (reg_req_i.rd) begin
            rdata_q <= '0;
            if (reg_req_i.addr == CTL_PIPE_CONTROL_OFS) begin
                rdata_q[BUF_FLAG_BIT]        <= buf_flag_q;
                rdata_q[TOG_MON_BIT]         <= toggle_q;
                rdata_q[BUSY_BIT]            <= busy_q;
                rdata_q[RESP_LSB +: 2]       <= resp_q;
            end else if (reg_req_i.addr == PIPE_WINDOW_SELECT_OFS) begin
                rdata_q[WIN_SEL_W-1:0]       <= win_sel_q;
            end else if (reg_req_i.addr == PIPE_CONFIGURATION_OFS) begin
                if (win_valid(win_sel_q)) begin
                    rdata_q <= cfg_q[win_index(win_sel_q)];
                end
            end else if (reg_req_i.addr == CTL_PIPE_AUX_OFS) begin
                rdata_q[PORT_DIR_BIT]        <= port_dir_q;
                rdata_q[SETUP_FLAG_BIT]      <= setup_flag_q;
                rdata_q[AUTO_ADDR_BIT]       <= auto_addr_q;
            end
        end else begin
            rdata_q <= '0;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_o     = rdata_q;
    assign ctl_response_o  = resp_q;
    assign ctl_toggle_o    = toggle_q;
    assign ctl_status_go_o = status_go_q;
    assign ctl_auto_addr_o = auto_addr_q;
    assign pipe_stop_o     = stop_q;

    // Configuration fields drive the pipe engines
    always_comb begin
        for (int i = 0; i < NUM_PIPES; i++) begin
            pipe_cfg_o[i] = cfg_q[i];
        end
    end

endmodule

// ### pkg/ucp_pkg.sv
package ucp_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] CTL_PIPE_CONTROL_OFS   = 8'h60;
    localparam logic [7:0] PIPE_WINDOW_SELECT_OFS = 8'h64;
    localparam logic [7:0] PIPE_CONFIGURATION_OFS = 8'h68;
    localparam logic [7:0] CTL_PIPE_AUX_OFS       = 8'h70;

    // Control pipe control register fields
    localparam int BUF_FLAG_BIT     = 15;
    localparam int TOG_CLR_BIT      = 8;
    localparam int TOG_SET_BIT      = 7;
    localparam int TOG_MON_BIT      = 6;
    localparam int BUSY_BIT         = 5;
    localparam int STAT_CPL_BIT     = 2;
    localparam int RESP_LSB         = 0;

    // Auxiliary register fields
    localparam int PORT_DIR_BIT     = 0;
    localparam int SETUP_FLAG_BIT   = 1;
    localparam int AUTO_ADDR_BIT    = 2;

    // Window select
    localparam int              WIN_SEL_W    = 4;
    localparam logic [3:0]      WIN_NONE     = 4'h0;
    localparam logic [3:0]      WIN_LAST     = 4'h9;
    localparam int              NUM_PIPES    = 9;

    // Writable mask of the pipe configuration register
    localparam logic [15:0] PIPE_CFG_MASK = 16'hc79f;

    // Reset values
    localparam logic [15:0] PIPE_CFG_RST  = 16'h0000;
    localparam logic        TOG_MON_RST   = 1'b1;
    localparam logic [3:0]  WIN_SEL_RST   = 4'h0;

    // Handshake response encoding
    typedef enum logic [1:0] {
        RESP_NAK    = 2'b00,
        RESP_BUF    = 2'b01,
        RESP_STALL2 = 2'b10,
        RESP_STALL  = 2'b11
    } ucp_resp_t;

    // Transfer type encoding
    typedef enum logic [1:0] {
        XFER_OFF  = 2'b00,
        XFER_BULK = 2'b01,
        XFER_INTR = 2'b10,
        XFER_ISO  = 2'b11
    } ucp_xfer_t;

    // Per-pipe configuration layout
    typedef struct packed {
        ucp_xfer_t  xfer_type;              // 15:14
        logic [2:0] rsv_hi;                 // 13:11
        logic       ready_timing_select;    // 10
        logic       double_buffer_enable;   // 9
        logic       continuous_mode_enable; // 8
        logic       stop_at_end_enable;     // 7
        logic [1:0] rsv_mid;                // 6:5
        logic       direction;              // 4
        logic [3:0] endpoint_number;        // 3:0
    } ucp_pipe_cfg_t;

    // Events from the USB protocol engine for the control pipe
    typedef struct packed {
        logic setup_rcvd;     // Setup packet received correctly
        logic set_address;    // SET_ADDRESS request detected
        logic xact_start;     // Transaction on the pipe begins
        logic xact_done;      // Transaction completed normally
        logic pid_mismatch;   // Received DATA RESPONSE_SELECT did not match
        logic status_stage;   // Current transaction is in status stage
        logic oversize;       // Data beyond max packet size arrived
        logic seq_error;      // Control transfer sequence error
        logic bus_reset;      // USB bus reset detected
    } ucp_link_evt_t;

    // Buffer state of the control pipe FIFO
    typedef struct packed {
        logic rx_readable;    // Received data can be read
        logic tx_writable;    // Transmit data can be written
    } ucp_buf_state_t;

    // Register access port
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ucp_reg_req_t;

endpackage

// ### bench/ucp_ctrl_pipe_sva.sv
`timescale 1ns/1ps
module ucp_ctrl_pipe_sva (
    input wire logic                         clk_i,
    input wire logic                         reset_n_i,
    input wire ucp_pkg::ucp_reg_req_t        reg_req_i,
    input wire logic [15:0]                  reg_rdata_o,
    input wire ucp_pkg::ucp_link_evt_t       link_evt_i,
    input wire ucp_pkg::ucp_buf_state_t      buf_state_i,
    input wire logic [8:0]                   pipe_xfer_end_i,
    input wire ucp_pkg::ucp_resp_t           ctl_response_o,
    input wire logic                         ctl_toggle_o,
    input wire logic                         ctl_status_go_o,
    input wire logic                         ctl_auto_addr_o,
    input wire logic [8:0]                   pipe_stop_o,
    input wire ucp_pkg::ucp_pipe_cfg_t [8:0] pipe_cfg_o
);
    import ucp_pkg::*;
    logic [3:0] win_q;
    logic [8:0] stop_due;
    logic       quiet;
    // Shadow of the window select
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            win_q <= WIN_SEL_RST;
        end else if (reg_req_i.wr && reg_req_i.addr == PIPE_WINDOW_SELECT_OFS) begin
            win_q <= reg_req_i.wdata[3:0];
        end
    end
    // Receiving pipes armed to stop
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            stop_due[i] = pipe_xfer_end_i[i] && pipe_cfg_o[i].stop_at_end_enable
                          && !pipe_cfg_o[i].direction;
        end
    end
    assign quiet = !link_evt_i.setup_rcvd && !link_evt_i.bus_reset && !reg_req_i.wr;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence setup_clean;
        link_evt_i.setup_rcvd && !link_evt_i.set_address && !link_evt_i.bus_reset
        ##1 !ctl_auto_addr_o;
    endsequence
    AST_SETUP_NAK: assert property (
        link_evt_i.setup_rcvd |=> ctl_response_o == RESP_NAK && ctl_toggle_o)
        else $error("setup did not give NAK and DATA1");
    AST_BUS_RESET_NAK: assert property (
        link_evt_i.bus_reset |=> ctl_response_o == RESP_NAK)
        else $error("bus reset did not give NAK");
    AST_OVERSIZE_STALL: assert property (
        link_evt_i.oversize && ctl_response_o == RESP_BUF && quiet
        |=> ctl_response_o == RESP_STALL)
        else $error("oversize did not stall");
    AST_SEQ_ERR_STALL: assert property (
        link_evt_i.seq_error && quiet |=> ctl_response_o[1])
        else $error("sequence error did not stall");
    AST_TOGGLE_FLIP: assert property (
        link_evt_i.xact_done && !link_evt_i.pid_mismatch && !link_evt_i.status_stage
        && quiet |=> ctl_toggle_o != $past(ctl_toggle_o))
        else $error("toggle did not flip");
    AST_TOGGLE_HOLD: assert property (
        link_evt_i.xact_done && (link_evt_i.pid_mismatch || link_evt_i.status_stage)
        && quiet |=> $stable(ctl_toggle_o))
        else $error("toggle moved");
    AST_TOGGLE_CLEAR: assert property (
        reg_req_i.wr && reg_req_i.addr == CTL_PIPE_CONTROL_OFS && reg_req_i.wdata[8]
        && !link_evt_i.setup_rcvd |=> !ctl_toggle_o)
        else $error("toggle clear ignored");
    AST_STOP_PULSE: assert property (
        1'b1 |=> pipe_stop_o == $past(stop_due))
        else $error("stop pulse wrong");
    AST_WIN_OFF_ZERO: assert property (
        reg_req_i.rd && reg_req_i.addr == PIPE_CONFIGURATION_OFS
        && (win_q == WIN_NONE || win_q > WIN_LAST) |=> reg_rdata_o == 16'h0000)
        else $error("closed window read not zero");
    AST_AUTO_ADDR_GO: assert property (
        ctl_auto_addr_o |=> ctl_status_go_o)
        else $error("auto address without status go");
    AST_SETUP_NO_GO: assert property (
        setup_clean |=> !ctl_status_go_o)
        else $error("status go after setup");
endmodule

// ### bench/ucp_host_model.sv
`timescale 1ns/1ps
module ucp_host_model (
    input  wire logic             clk_i,
    output ucp_pkg::ucp_link_evt_t  link_evt_o,
    output ucp_pkg::ucp_buf_state_t buf_state_o,
    output logic [8:0]            xfer_end_o
);
    import ucp_pkg::*;
    // Idle bus: no events, buffers busy
    initial begin
        link_evt_o <= '0;
        buf_state_o <= '0;
        xfer_end_o <= '0;
    end
    // One-cycle bus event, then back to idle
    task automatic send(input ucp_link_evt_t e, input logic [8:0] x);
        @(posedge clk_i);
        link_evt_o <= e;
        xfer_end_o <= x;
        @(posedge clk_i);
        link_evt_o <= '0;
        xfer_end_o <= '0;
    endtask
    // Buffer levels
    task automatic set_buf(input logic rx, input logic tx);
        @(posedge clk_i);
        buf_state_o <= '{rx_readable: rx, tx_writable: tx};
    endtask
endmodule

// ### bench/test_usb_control_pipe_and_pipe_config.sv
`timescale 1ns/1ps
module test_usb_control_pipe_and_pipe_config;
    import ucp_pkg::*;
    localparam logic [8:0] EV_SETUP = 9'h100, EV_ADDR = 9'h080, EV_START = 9'h040;
    localparam logic [8:0] EV_DONE = 9'h020, EV_MISM = 9'h030, EV_STAT = 9'h028;
    localparam logic [8:0] EV_OVER = 9'h004, EV_SEQ = 9'h002, EV_BRST = 9'h001;
    logic                clk_i, reset_n_i, tog, go, aadr;
    ucp_reg_req_t        req;
    logic [15:0]         rdata, d;
    ucp_link_evt_t       evt;
    ucp_buf_state_t      bst;
    logic [8:0]          xend, stop;
    ucp_resp_t           resp;
    ucp_pipe_cfg_t [8:0] cfg;
    int                  n_mismatch = 0, check_count = 0, cyc = 0;
    ucp_ctrl_pipe ucp_ctrl_pipe_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .link_evt_i(evt), .buf_state_i(bst),
        .pipe_xfer_end_i(xend), .ctl_response_o(resp), .ctl_toggle_o(tog),
        .ctl_status_go_o(go), .ctl_auto_addr_o(aadr), .pipe_stop_o(stop), .pipe_cfg_o(cfg));
    ucp_host_model ucp_host_model_inst (.clk_i(clk_i), .link_evt_o(evt),
        .buf_state_o(bst), .xfer_end_o(xend));
    // 200 MHz clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: timeout", $time);
            end_of_test;
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_i);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_i);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    function automatic logic [15:0] cfgv(input int i);
        return {i[1:0], 2'h0, i[3:0], i[3:0], i[3:0]};
    endfunction
    task automatic t_window;
        for (int i = 1; i <= 9; i++) begin
            wr(PIPE_WINDOW_SELECT_OFS, 16'(i));
            wr(PIPE_CONFIGURATION_OFS, cfgv(i));
        end
        for (int i = 9; i >= 1; i--) begin
            wr(PIPE_WINDOW_SELECT_OFS, 16'(i));
            rd(PIPE_CONFIGURATION_OFS, d);
            chk(d, cfgv(i) & PIPE_CFG_MASK);
            chk(cfg[i-1], cfgv(i) & PIPE_CFG_MASK);
        end
        rd(PIPE_WINDOW_SELECT_OFS, d);
        chk(d, 16'h0001);
        wr(PIPE_WINDOW_SELECT_OFS, 16'h0000);
        wr(PIPE_CONFIGURATION_OFS, 16'hffff);
        rd(PIPE_CONFIGURATION_OFS, d);
        chk(d, 16'h0000);
        chk(cfg[0], cfgv(1) & PIPE_CFG_MASK);
        wr(PIPE_WINDOW_SELECT_OFS, 16'h000a);
        rd(PIPE_CONFIGURATION_OFS, d);
        chk(d, 16'h0000);
        $display("test window done");
    endtask
    task automatic t_toggle;
        rd(CTL_PIPE_CONTROL_OFS, d);
        chk(d & 16'h0167, 16'h0040);
        wr(CTL_PIPE_CONTROL_OFS, 16'h0100);
        rd(CTL_PIPE_CONTROL_OFS, d);
        chk(d[8:6], 3'b000);
        wr(CTL_PIPE_CONTROL_OFS, 16'h0080);
        rd(CTL_PIPE_CONTROL_OFS, d);
        chk(d[8:6], 3'b001);
        ucp_host_model_inst.send(EV_START, 9'h000);
        rd(CTL_PIPE_CONTROL_OFS, d);
        chk(d[6:5], 2'b11);
        ucp_host_model_inst.send(EV_DONE, 9'h000);
        rd(CTL_PIPE_CONTROL_OFS, d);
        chk(d[6:5], 2'b00);
        ucp_host_model_inst.send(EV_MISM, 9'h000);
        ucp_host_model_inst.send(EV_STAT, 9'h000);
        #1 chk(tog, 1'b0);
        ucp_host_model_inst.send(EV_DONE, 9'h000);
        #1 chk(tog, 1'b1);
        $display("test toggle done");
    endtask
    task automatic t_setup;
        wr(CTL_PIPE_CONTROL_OFS, 16'h0100);
        ucp_host_model_inst.send(EV_SETUP, 9'h000);
        #1 chk({tog, resp}, 3'b100);
        rd(CTL_PIPE_AUX_OFS, d);
        chk(d[1], 1'b1);
        wr(CTL_PIPE_CONTROL_OFS, 16'h0005);
        @(posedge clk_i);
        #1 chk({go, resp}, 3'b000);
        wr(CTL_PIPE_AUX_OFS, 16'h0000);
        wr(CTL_PIPE_CONTROL_OFS, 16'h0005);
        @(posedge clk_i);
        #1 chk({go, resp}, 3'b101);
        ucp_host_model_inst.send(EV_SETUP, 9'h000);
        @(posedge clk_i);
        #1 chk(go, 1'b0);
        wr(CTL_PIPE_AUX_OFS, 16'h0000);
        $display("test setup done");
    endtask
    task automatic t_stall;
        wr(CTL_PIPE_CONTROL_OFS, 16'h0001);
        ucp_host_model_inst.send(EV_OVER, 9'h000);
        #1 chk(resp, RESP_STALL);
        wr(CTL_PIPE_CONTROL_OFS, 16'h0001);
        ucp_host_model_inst.send(EV_SEQ, 9'h000);
        #1 chk(resp[1], 1'b1);
        ucp_host_model_inst.send(EV_BRST, 9'h000);
        #1 chk(resp, RESP_NAK);
        ucp_host_model_inst.send(EV_OVER, 9'h000);
        #1 chk(resp, RESP_NAK);
        ucp_host_model_inst.send(EV_ADDR, 9'h000);
        @(posedge clk_i);
        #1 chk({aadr, go}, 2'b11);
        rd(CTL_PIPE_AUX_OFS, d);
        chk(d[2], 1'b1);
        ucp_host_model_inst.send(EV_BRST, 9'h000);
        $display("test stall done");
    endtask
    task automatic t_buf_stop;
        ucp_host_model_inst.set_buf(1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            if (i == 2) ucp_host_model_inst.set_buf(1'b0, 1'b1);
            wr(CTL_PIPE_AUX_OFS, 16'(i % 2));
            rd(CTL_PIPE_CONTROL_OFS, d);
            chk(d[15], 1'((i == 0) || (i == 3)));
        end
        wr(PIPE_WINDOW_SELECT_OFS, 16'h0001);
        wr(PIPE_CONFIGURATION_OFS, 16'h4081);
        wr(PIPE_WINDOW_SELECT_OFS, 16'h0002);
        wr(PIPE_CONFIGURATION_OFS, 16'h4092);
        ucp_host_model_inst.send('0, 9'h003);
        #1 chk(stop, 9'h001);
        @(posedge clk_i);
        #1 chk(stop, 9'h000);
        $display("test buffer and stop done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Reset, then the scenarios
    initial begin
        reset_n_i <= 1'b0;
        req <= '0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_toggle;
        t_window;
        t_setup;
        t_stall;
        t_buf_stop;
        end_of_test;
    end
endmodule
bind ucp_ctrl_pipe ucp_ctrl_pipe_sva ucp_ctrl_pipe_sva_inst (.clk_i, .reset_n_i, .reg_req_i,
    .reg_rdata_o, .link_evt_i, .buf_state_i, .pipe_xfer_end_i, .ctl_response_o, .ctl_toggle_o,
    .ctl_status_go_o, .ctl_auto_addr_o, .pipe_stop_o, .pipe_cfg_o);
